/* dv/fetch_model.sv */
// fetch responder: fixed actual position and index-derived stored coordinates
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // fetch request and answer
    input  wire logic        req_i,
    input  wire logic        stored_coordinate_type_i,
    input  wire logic [7:0]  index_i,
    input  wire logic [3:0]  delay_i,
    output logic             ack_o,
    output logic [31:0]      data_o
);
    logic [3:0] wait_cnt;
    logic       busy;

    always_ff @(posedge clock_i)
    begin
        ack_o  <= 1'b0;
        // scrambled outside the ack cycle so stale data cannot pass
        data_o <= rst_n_i ? ~data_o : 32'h0;
        if (!rst_n_i)
            busy <= 1'b0;
        else if (req_i)
        begin
            busy     <= 1'b1;
            wait_cnt <= delay_i;
        end
        else if (busy && wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else if (busy)
        begin
            busy   <= 1'b0;
            ack_o  <= 1'b1;
            // stored coordinates are formed from the index; actual position is a fixed value
            data_o <= stored_coordinate_type_i ? {24'hc00000, index_i} : 32'h7fff_fff0;
        end
    end
endmodule
`default_nettype wire

/* dv/motion_command_decoder_bench.sv */
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defs.svh"
module motion_command_decoder_bench;
    logic                      clock_i = 1'b0;
    logic                      rst_n_i = 1'b0;
    logic [7:0]                rx_byte_i = 8'h00;
    logic                      rx_valid_i = 1'b0;
    logic [3:0]                delay = 4'h3;
    logic                      rx_ready_o, mode_wr_o, param_wr_o;
    logic                      fetch_req_o, fetch_stored_coordinate_type_o, fetch_ack_i;
    logic                      reply_valid_o;
    logic [2:0]                fetch_axis_o;
    logic [7:0]                fetch_index_o;
    logic [31:0]               fetch_data_i;
    motion_cmd_pkg::mode_wr_t  mode_o, mode_s;
    motion_cmd_pkg::param_wr_t param_o, param_s;
    motion_cmd_pkg::reply_t    reply_o, reply_s;
    int                        mode_c, param_c, reply_c, t0, cyc = 0;
    int                        bad_count = 0;
    int                        tests_run = 0;

    motion_command_decoder motion_command_decoder_inst
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .rx_byte_i(rx_byte_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .mode_wr_o(mode_wr_o), .mode_o(mode_o),
        .param_wr_o(param_wr_o), .param_o(param_o),
        .fetch_req_o(fetch_req_o), .fetch_stored_coordinate_type_o(fetch_stored_coordinate_type_o),
        .fetch_axis_o(fetch_axis_o), .fetch_index_o(fetch_index_o),
        .fetch_ack_i(fetch_ack_i), .fetch_data_i(fetch_data_i),
        .reply_valid_o(reply_valid_o), .reply_o(reply_o)
    );
    fetch_model fetch_model_inst
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(fetch_req_o),
        .stored_coordinate_type_i(fetch_stored_coordinate_type_o), .index_i(fetch_index_o),
        .delay_i(delay), .ack_o(fetch_ack_i), .data_o(fetch_data_i)
    );

    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    // pulses last one cycle, so they are caught at the settled edge
    always @(negedge clock_i)
    begin
        if (mode_wr_o === 1'b1) {mode_c, mode_s} = {cyc, mode_o};
        if (param_wr_o === 1'b1) {param_c, param_s} = {cyc, param_o};
        if (reply_valid_o === 1'b1) {reply_c, reply_s} = {cyc, reply_o};
    end
    always @(posedge clock_i)
    begin
        if (cyc == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] ins, kind, axis,
                        input logic [31:0] val, input logic [7:0] skew);
        logic [7:0] b [9];
        b = '{8'h01, ins, kind, axis, val[31:24], val[23:16], val[15:8],
              val[7:0], skew};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        {mode_c, param_c, reply_c} = '0;
        for (int i = 0; i < 9; i++)
        begin
            @(negedge clock_i);
            rx_valid_i = 1'b1;
            rx_byte_i = b[i];
            while (rx_ready_o !== 1'b1) @(negedge clock_i);
            @(posedge clock_i);
        end
        @(negedge clock_i);
        rx_valid_i = 1'b0;
        t0 = cyc;
        for (int i = 0; i < 40 && reply_c == 0; i++) @(negedge clock_i);
    endtask

    task automatic t_rotate();
        send(`INSTR_ROT_INC, 8'h00, 8'h01, 32'h0000_c800, 8'h00);
        check(mode_s, {3'h1, 2'b11});
        check(param_s, {3'h1, `PARAM_TARGET_VEL, 32'h0000_c800});
        check(param_c - mode_c, 1);
        check(reply_s, {`STATUS_OK, `INSTR_ROT_INC, `ZERO_VALUE});
        send(`INSTR_ROT_DEC, 8'h00, 8'h05, 32'h8000_0000, 8'h00);
        check(mode_s, {3'h5, 2'b10});
        check(param_s, {3'h5, `PARAM_TARGET_VEL, 32'h8000_0000});
        send(`INSTR_STOP, 8'h00, 8'h03, 32'h0, 8'h00);
        check(mode_s, {3'h3, 2'b11});
        check(param_s, {3'h3, `PARAM_TARGET_SPD, 32'h0});
        check(param_c - mode_c, 1);
        check(reply_s, {`STATUS_OK, `INSTR_STOP, `ZERO_VALUE});
    endtask

    task automatic t_move();
        send(`INSTR_MOVE, `MOVE_ABSOLUTE, 8'h02, 32'h7fff_ffff, 8'h00);
        check({mode_s.axis, mode_s.velocity_mode}, {3'h2, 1'b0});
        check(param_s, {3'h2, `PARAM_TARGET_POS, 32'h7fff_ffff});
        check(reply_c - t0, 3);
        check(reply_s, {`STATUS_OK, `INSTR_MOVE, `ZERO_VALUE});
        send(`INSTR_ROT_INC, 8'h00, 8'h02, 32'h10, 8'h00);
        check(mode_s, {3'h2, 2'b11});
        // offset keeps the sum in range; the carry out is dropped
        send(`INSTR_MOVE, `MOVE_RELATIVE, 8'h04, 32'hffff_fff0, 8'h00);
        check({fetch_stored_coordinate_type_o, fetch_axis_o}, {1'b0, 3'h4});
        check(param_s, {3'h4, `PARAM_TARGET_POS, 32'h7fff_ffe0});
        check(reply_s.status, `STATUS_OK);
        delay = 4'h0;
        send(`INSTR_MOVE, `MOVE_COORDINATE, 8'h00, 32'h8, 8'h00);
        check({fetch_stored_coordinate_type_o, fetch_index_o}, {1'b1, 8'h08});
        check(param_s, {3'h0, `PARAM_TARGET_POS, 32'hc000_0008});
    endtask

    task automatic t_param_err();
        send(`INSTR_SET_PARAM, 8'h04, 8'h00, 32'h0000_c800, 8'h00);
        check(param_s, {3'h0, 8'h04, 32'h0000_c800});
        check(mode_c, 0);
        check(reply_s.status, `STATUS_OK);
        send(8'h07, 8'h00, 8'h00, 32'h1, 8'h00);
        check(reply_s.status, `STATUS_BAD_CMD);
        send(`INSTR_MOVE, 8'h03, 8'h00, 32'h1, 8'h00);
        check(reply_s.status, `STATUS_BAD_TYPE);
        send(`INSTR_ROT_INC, 8'h00, `AXIS_COUNT, 32'h1, 8'h00);
        check(reply_s.status, `STATUS_BAD_VALUE);
        check(param_c + mode_c, 0);
        send(`INSTR_STOP, 8'h00, 8'h00, 32'h0, 8'h01);
        check(reply_c, 0);
        check(rx_ready_o, 1'b1);
    endtask

    initial
    begin
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        t_rotate();
        t_move();
        t_param_err();
        stop_test();
    end
endmodule
`default_nettype wire

/* hw/motion_command_decoder.sv */
// decoder for rotate, stop, move and set-parameter command frames
`include "motion_cmd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module motion_command_decoder
(
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    // command byte stream
    input  wire logic [7:0]                rx_byte_i,
    input  wire logic                      rx_valid_i,
    output var  logic                      rx_ready_o,
    // axis mode selection
    output var  logic                      mode_wr_o,
    output var  motion_cmd_pkg::mode_wr_t  mode_o,
    // axis parameter write
    output var  logic                      param_wr_o,
    output var  motion_cmd_pkg::param_wr_t param_o,
    // position or coordinate fetch
    output var  logic                      fetch_req_o,
    output var  logic                      fetch_stored_coordinate_type_o,
    output var  logic [2:0]                fetch_axis_o,
    output var  logic [7:0]                fetch_index_o,
    input  wire logic                      fetch_ack_i,
    input  wire logic [31:0]               fetch_data_i,
    // direct mode reply
    output var  logic                      reply_valid_o,
    output var  motion_cmd_pkg::reply_t    reply_o
);

    motion_cmd_pkg::state_t state;
    logic [7:0]             frame_mem [0:8];
    logic [3:0]             byte_cnt;
    logic [7:0]             sum;
    motion_cmd_pkg::frame_t frame;

    // the value field arrives most significant byte first
    assign frame = {frame_mem[0], frame_mem[1], frame_mem[2],
                    frame_mem[3], frame_mem[4], frame_mem[5],
                    frame_mem[6], frame_mem[7], frame_mem[8]};

    function automatic motion_cmd_pkg::reply_t make_reply(
        input logic [7:0] status,
        input logic [7:0] instr
    );
        make_reply = '{status: status, instr: instr, value: `ZERO_VALUE};
    endfunction

    wire logic take = rx_valid_i && rx_ready_o;
    wire logic last = (byte_cnt == `LAST_BYTE_IDX);
    wire logic axis_ok = (frame.axis < `AXIS_COUNT);
    wire logic [2:0] axis3 = frame.axis[2:0];

    // frame assembly; a frame with a bad checksum is dropped silently
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            byte_cnt <= 4'h0;
            sum      <= 8'h00;
        end
        else if (take)
        begin
            frame_mem[byte_cnt] <= rx_byte_i;
            byte_cnt <= last ? 4'h0 : byte_cnt + 4'h1;
            sum      <= last ? 8'h00 : sum + rx_byte_i;
        end
    end

    // sequencing of writes and reply
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state         <= motion_cmd_pkg::ST_COLLECT;
            rx_ready_o    <= 1'b0;
            mode_wr_o     <= 1'b0;
            mode_o        <= '0;
            param_wr_o    <= 1'b0;
            param_o       <= '0;
            fetch_req_o   <= 1'b0;
            fetch_stored_coordinate_type_o <= 1'b0;
            fetch_axis_o  <= 3'h0;
            fetch_index_o <= 8'h00;
            reply_valid_o <= 1'b0;
            reply_o       <= '0;
        end
        else
        begin
            mode_wr_o     <= 1'b0;
            param_wr_o    <= 1'b0;
            fetch_req_o   <= 1'b0;
            reply_valid_o <= 1'b0;
            unique case (state)
            motion_cmd_pkg::ST_COLLECT:
            begin
                rx_ready_o <= 1'b1;
                if (take && last && (rx_byte_i == sum))
                begin
                    rx_ready_o <= 1'b0;
                    state      <= motion_cmd_pkg::ST_DECODE;
                end
            end
            motion_cmd_pkg::ST_DECODE:
            begin
                state   <= motion_cmd_pkg::ST_REPLY;
                reply_o <= make_reply(`STATUS_OK, frame.instr);
                if (!axis_ok)
                    reply_o <= make_reply(`STATUS_BAD_VALUE,
                                          frame.instr);
                else if (frame.instr == `INSTR_ROT_INC ||
                         frame.instr == `INSTR_ROT_DEC)
                begin
                    // velocity mode first; it also ends a running move
                    mode_wr_o <= 1'b1;
                    mode_o    <= '{axis: axis3, velocity_mode: 1'b1,
                                   increasing: frame.instr ==
                                   `INSTR_ROT_INC};
                    param_o   <= '{axis: axis3, num: `PARAM_TARGET_VEL,
                                   data: frame.value};
                    state     <= motion_cmd_pkg::ST_PARAM;
                end
                else if (frame.instr == `INSTR_STOP)
                begin
                    mode_wr_o <= 1'b1;
                    mode_o    <= '{axis: axis3, velocity_mode: 1'b1,
                                   increasing: 1'b1};
                    param_o   <= '{axis: axis3, num: `PARAM_TARGET_SPD,
                                   data: `ZERO_VALUE};
                    state     <= motion_cmd_pkg::ST_PARAM;
                end
                else if (frame.instr == `INSTR_MOVE)
                begin
                    if (frame.kind > `MOVE_COORDINATE)
                        reply_o <= make_reply(`STATUS_BAD_TYPE,
                                              frame.instr);
                    else
                    begin
                        // ramp limits stay those already in the axis
                        mode_wr_o <= 1'b1;
                        mode_o    <= '{axis: axis3, velocity_mode: 1'b0,
                                       increasing: 1'b1};
                        param_o   <= '{axis: axis3, num: `PARAM_TARGET_POS,
                                       data: frame.value};
                        state     <= motion_cmd_pkg::ST_PARAM;
                        if (frame.kind != `MOVE_ABSOLUTE)
                        begin
                            fetch_req_o   <= 1'b1;
                            fetch_stored_coordinate_type_o <= (frame.kind ==
                                              `MOVE_COORDINATE);
                            fetch_axis_o  <= axis3;
                            fetch_index_o <= frame.value[7:0];
                            state         <= motion_cmd_pkg::ST_FETCH;
                        end
                    end
                end
                else if (frame.instr == `INSTR_SET_PARAM)
                begin
                    // axis parameters live in volatile storage outside
                    param_o <= '{axis: axis3, num: frame.kind,
                                 data: frame.value};
                    state   <= motion_cmd_pkg::ST_PARAM;
                end
                else
                    reply_o <= make_reply(`STATUS_BAD_CMD, frame.instr);
            end
            motion_cmd_pkg::ST_FETCH:
            begin
                if (fetch_ack_i)
                begin
                    param_wr_o <= 1'b1;
                    // relative sum wraps modulo two to the 32
                    param_o.data <= fetch_stored_coordinate_type_o ? fetch_data_i
                                  : 32'(fetch_data_i + param_o.data);
                    state      <= motion_cmd_pkg::ST_REPLY;
                end
            end
            motion_cmd_pkg::ST_PARAM:
            begin
                param_wr_o <= 1'b1;
                state      <= motion_cmd_pkg::ST_REPLY;
            end
            motion_cmd_pkg::ST_REPLY:
            begin
                // no waiting for motion to finish
                reply_valid_o <= 1'b1;
                rx_ready_o    <= 1'b1;
                state         <= motion_cmd_pkg::ST_COLLECT;
            end
            default:
                state <= motion_cmd_pkg::ST_COLLECT;
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    rotate_mode_first_a: assert property (
        state == motion_cmd_pkg::ST_DECODE && axis_ok &&
        (frame.instr == `INSTR_ROT_INC || frame.instr == `INSTR_ROT_DEC)
        |=> mode_wr_o && !param_wr_o ##1 !mode_wr_o && param_wr_o &&
        param_o.num == `PARAM_TARGET_VEL && param_o.data == frame.value)
        else $error("velocity write not preceded by mode select");
    rotate_dir_a: assert property (
        mode_wr_o && mode_o.velocity_mode |->
        mode_o.increasing == ($past(frame.instr) != `INSTR_ROT_DEC))
        else $error("rotate direction wrong");
    stop_zero_a: assert property (
        mode_wr_o && $past(frame.instr) == `INSTR_STOP |=>
        param_wr_o && param_o.data == `ZERO_VALUE &&
        param_o.num == `PARAM_TARGET_SPD)
        else $error("stop did not zero target speed");
    reply_after_write_a: assert property (
        param_wr_o |=> reply_valid_o)
        else $error("reply not issued after write");
    bad_axis_a: assert property (
        state == motion_cmd_pkg::ST_DECODE && !axis_ok |=>
        !mode_wr_o ##1 !param_wr_o && reply_valid_o &&
        reply_o.status == `STATUS_BAD_VALUE)
        else $error("bad axis changed a parameter");
    move_status_a: assert property (
        state == motion_cmd_pkg::ST_DECODE && axis_ok &&
        frame.instr == `INSTR_MOVE && frame.kind == `MOVE_ABSOLUTE |=>
        ##2 reply_valid_o && reply_o.status == `STATUS_OK)
        else $error("move reply missing or not ok");
    stored_coordinate_type_target_a: assert property (
        state == motion_cmd_pkg::ST_FETCH && fetch_ack_i && fetch_stored_coordinate_type_o
        |=> param_wr_o && param_o.data == $past(fetch_data_i))
        else $error("stored coordinate not used as target");
    rel_wrap_a: assert property (
        state == motion_cmd_pkg::ST_FETCH && fetch_ack_i && !fetch_stored_coordinate_type_o
        |=> param_o.data == 32'($past(fetch_data_i) + $past(param_o.data)))
        else $error("relative target not a wrapped sum");
    busy_stall_a: assert property (
        state == motion_cmd_pkg::ST_DECODE |-> !rx_ready_o)
        else $error("bytes accepted while decoding");

endmodule

`default_nettype wire

/* shared/motion_cmd_defs.svh */
// constants for the motion command decoder
`ifndef MOTION_CMD_DEFS_SVH
`define MOTION_CMD_DEFS_SVH

`define FRAME_BYTES       4'h9
`define LAST_BYTE_IDX     4'h8
`define AXIS_COUNT        8'h06

`define INSTR_ROT_INC     8'h01
`define INSTR_ROT_DEC     8'h02
`define INSTR_STOP        8'h03
`define INSTR_MOVE        8'h04
`define INSTR_SET_PARAM   8'h05

`define MOVE_ABSOLUTE     8'h00
`define MOVE_RELATIVE     8'h01
`define MOVE_COORDINATE   8'h02

`define PARAM_TARGET_POS  8'h00
`define PARAM_TARGET_SPD  8'h00
`define PARAM_TARGET_VEL  8'h02

`define STATUS_OK         8'h64
`define STATUS_BAD_CMD    8'h02
`define STATUS_BAD_TYPE   8'h03
`define STATUS_BAD_VALUE  8'h04

`define ZERO_VALUE        32'h0000_0000

`endif

/* shared/motion_cmd_pkg.sv */
// types shared by the motion command decoder
package motion_cmd_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  instr;
        logic [7:0]  kind;
        logic [7:0]  axis;
        logic [31:0] value;
        logic [7:0]  csum;
    } frame_t;

    typedef struct packed {
        logic [2:0]  axis;
        logic [7:0]  num;
        logic [31:0] data;
    } param_wr_t;

    typedef struct packed {
        logic [2:0] axis;
        logic       velocity_mode;
        logic       increasing;
    } mode_wr_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  instr;
        logic [31:0] value;
    } reply_t;

    typedef enum logic [4:0] {
        ST_COLLECT = 5'h01,
        ST_DECODE  = 5'h02,
        ST_PARAM   = 5'h04,
        ST_FETCH   = 5'h08,
        ST_REPLY   = 5'h10
    } state_t;

endpackage
